/* logic/trm_consts.svh */
`ifndef TRM_CONSTS_SVH
`define TRM_CONSTS_SVH

// ****************************************************************
// Destination-port filter modes
// ****************************************************************
`define TRM_DPORT_ANY 2'h0
`define TRM_DPORT_EXACT 2'h1
`define TRM_DPORT_RANGE 2'h2

// ****************************************************************
// Three-state flag settings
// ****************************************************************
`define TRM_FLAG_CLEAR 2'h0
`define TRM_FLAG_SET 2'h1
`define TRM_FLAG_ANY 2'h2

// ****************************************************************
// Flag positions in the flag vector
// ****************************************************************
`define TRM_FIN_BIT 0
`define TRM_SYN_BIT 1
`define TRM_PSH_BIT 2
`define TRM_ACK_BIT 3
`define TRM_URG_BIT 4
`define TRM_NUM_FLAGS 5

// ****************************************************************
// Reset values
// ****************************************************************
`define TRM_PORT_RST 16'h0000
`define TRM_FLAGS_RST 5'h00

`endif

/* logic/trm_pkg.sv */
package trm_pkg;

    typedef enum logic [1:0] {
        TRM_DP_ANY = 2'h0,
        TRM_DP_EXACT = 2'h1,
        TRM_DP_RANGE = 2'h2
    } trm_dport_mode_t;

    typedef enum logic [1:0] {
        TRM_FL_CLEAR = 2'h0,
        TRM_FL_SET = 2'h1,
        TRM_FL_ANY = 2'h2
    } trm_flag_sel_t;

    // One access_rule_entry's destination-port and flag criteria
    typedef struct packed {
        trm_dport_mode_t dport_mode;
        logic [15:0] dport_lo;
        logic [15:0] dport_hi;
        trm_flag_sel_t fin_sel;
        trm_flag_sel_t syn_sel;
        trm_flag_sel_t psh_sel;
        trm_flag_sel_t ack_sel;
        trm_flag_sel_t urg_sel;
    } trm_rule_cfg_t;

    // Fields extracted from one frame by the parser
    typedef struct packed {
        logic [15:0] dport;
        logic [4:0] flags;
    } trm_frame_hdr_t;

endpackage

/* logic/trm_flag_check.sv */
`timescale 1ns/1ps
`include "trm_consts.svh"

module trm_flag_check
    import trm_pkg::*;
(
    // Settings
    input wire trm_flag_sel_t [`TRM_NUM_FLAGS-1:0] sel_i,
    // Frame flags
    input wire logic [`TRM_NUM_FLAGS-1:0] flags_i,
    // Result per flag
    output logic [`TRM_NUM_FLAGS-1:0] ok_o
);

    function automatic logic flag_ok(input trm_flag_sel_t sel, input logic bit_v);
        logic r;
        r = 1'b0;
        unique case (sel)
            TRM_FL_CLEAR: r = ~bit_v;
            TRM_FL_SET: r = bit_v;
            TRM_FL_ANY: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        ok_o[`TRM_FIN_BIT] = flag_ok(sel_i[`TRM_FIN_BIT], flags_i[`TRM_FIN_BIT]);
        ok_o[`TRM_SYN_BIT] = flag_ok(sel_i[`TRM_SYN_BIT], flags_i[`TRM_SYN_BIT]);
        ok_o[`TRM_PSH_BIT] = flag_ok(sel_i[`TRM_PSH_BIT], flags_i[`TRM_PSH_BIT]);
        ok_o[`TRM_ACK_BIT] = flag_ok(sel_i[`TRM_ACK_BIT], flags_i[`TRM_ACK_BIT]);
        ok_o[`TRM_URG_BIT] = flag_ok(sel_i[`TRM_URG_BIT], flags_i[`TRM_URG_BIT]);
    end

endmodule

/* logic/trm_rule_matcher.sv */
// Notes on behaviour
// - With the destination-port mode at any, every frame passes the port test.
// - In exact mode the frame passes only when its destination port equals the 16-bit value.
// - In range mode the frame passes when its destination port lies between the two bounds.
// - FIN setting 0 needs FIN clear, 1 needs FIN set, any ignores FIN.
// - SYN setting 0 needs SYN clear, 1 needs SYN set, any ignores SYN.
// - PSH setting 0 needs PSH clear, 1 needs PSH set, any ignores PSH.
// - ACK setting 0 needs ACK clear, 1 needs ACK set, any ignores ACK.
// - URG setting 0 needs URG clear, 1 needs URG set, any ignores URG.
`timescale 1ns/1ps
`include "trm_consts.svh"

// ****************************************************************
// Timing and limits
// ****************************************************************
// A header presented with hdr_valid_i high is judged against the
// settings present at the same edge; match_valid_o and match_o
// follow one cycle later and stand for that one cycle only.
// Headers may arrive back to back, and each is judged on its own.
// Settings are taken as levels and are not captured per frame, so a
// change while frames flow applies from the next sampling edge.
// The parser and this block share clk_i, so no input is resynchronised.
// Any two-bit setting left at code 3 disables the whole entry.
// After rst_i both outputs read low; the first header may come in the
// cycle after release.
// Exact mode compares against dport_lo; dport_hi is unused there.
// The block keeps no memory of earlier frames, so each verdict depends
// only on the header and the settings at its own edge.

module trm_rule_matcher
    import trm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Rule configuration
    input wire trm_rule_cfg_t cfg_i,
    // Frame from parser
    input wire logic hdr_valid_i,
    input wire trm_frame_hdr_t hdr_i,
    // Result
    output logic match_valid_o,
    output logic match_o
);

    // ****************************************************************
    // Port compare
    // ****************************************************************
    // The port is compared every way at once and the mode only picks a
    // result; the mux sits after the compares, so a mode change never
    // lengthens the path from hdr_i.
    logic [15:0] frame_port;
    logic [15:0] bound_lo;
    logic [15:0] bound_hi;
    trm_dport_mode_t port_mode;

    always_comb begin
        frame_port = hdr_i.dport;
        bound_lo = cfg_i.dport_lo;
        bound_hi = cfg_i.dport_hi;
        port_mode = cfg_i.dport_mode;
    end

    // Unsigned strict compare shared by both bounds and the order test
    function automatic logic above(input logic [15:0] a, input logic [15:0] b);
        return a > b;
    endfunction

    logic port_eq;
    logic port_at_hi;
    logic port_above_lo;
    logic port_below_hi;
    logic port_ge_lo;
    logic port_le_hi;
    logic bounds_inverted;
    logic exact_hit;
    logic range_hit;

    always_comb begin
        port_eq = (frame_port == bound_lo);
        port_at_hi = (frame_port == bound_hi);
        port_above_lo = above(frame_port, bound_lo);
        port_below_hi = above(bound_hi, frame_port);
        // Both end points count as inside the range
        port_ge_lo = port_above_lo | port_eq;
        port_le_hi = port_below_hi | port_at_hi;
        // Inverted bounds can never bracket a port; the explicit term keeps
        // that true even if the bound tests are ever relaxed
        bounds_inverted = above(bound_lo, bound_hi);
        exact_hit = port_eq;
        range_hit = ~bounds_inverted & port_ge_lo & port_le_hi;
    end

    logic port_ok;

    always_comb begin
        port_ok = 1'b0;
        unique case (port_mode)
            TRM_DP_ANY: port_ok = 1'b1;
            TRM_DP_EXACT: port_ok = exact_hit;
            TRM_DP_RANGE: port_ok = range_hit;
            default: port_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // Flag compare
    // ****************************************************************
    logic [`TRM_NUM_FLAGS-1:0] flag_ok;
    trm_flag_sel_t [`TRM_NUM_FLAGS-1:0] sel_vec;

    always_comb begin
        sel_vec[`TRM_FIN_BIT] = cfg_i.fin_sel;
        sel_vec[`TRM_SYN_BIT] = cfg_i.syn_sel;
        sel_vec[`TRM_PSH_BIT] = cfg_i.psh_sel;
        sel_vec[`TRM_ACK_BIT] = cfg_i.ack_sel;
        sel_vec[`TRM_URG_BIT] = cfg_i.urg_sel;
    end

    trm_flag_check u_flags (
        .sel_i(sel_vec),
        .flags_i(hdr_i.flags),
        .ok_o(flag_ok)
    );

    // ****************************************************************
    // Setting check
    // ****************************************************************
    // Code 3 is undefined for every two-bit setting; an entry that holds
    // it is treated as disabled rather than given a guessed meaning
    function automatic logic sel_legal(input trm_flag_sel_t sel);
        return (sel == TRM_FL_CLEAR) || (sel == TRM_FL_SET) || (sel == TRM_FL_ANY);
    endfunction

    logic mode_legal;
    logic [`TRM_NUM_FLAGS-1:0] sel_legal_vec;
    logic cfg_legal;

    always_comb begin
        mode_legal = (port_mode == TRM_DP_ANY) || (port_mode == TRM_DP_EXACT)
            || (port_mode == TRM_DP_RANGE);
        sel_legal_vec[`TRM_FIN_BIT] = sel_legal(sel_vec[`TRM_FIN_BIT]);
        sel_legal_vec[`TRM_SYN_BIT] = sel_legal(sel_vec[`TRM_SYN_BIT]);
        sel_legal_vec[`TRM_PSH_BIT] = sel_legal(sel_vec[`TRM_PSH_BIT]);
        sel_legal_vec[`TRM_ACK_BIT] = sel_legal(sel_vec[`TRM_ACK_BIT]);
        sel_legal_vec[`TRM_URG_BIT] = sel_legal(sel_vec[`TRM_URG_BIT]);
        cfg_legal = mode_legal & (&sel_legal_vec);
    end

    // ****************************************************************
    // Criteria combine
    // ****************************************************************
    logic fin_ok;
    logic syn_ok;
    logic psh_ok;
    logic ack_ok;
    logic urg_ok;
    // One bit per criterion: port first, then the five flags in order
    logic [`TRM_NUM_FLAGS:0] crit_ok;
    logic all_ok;

    // An illegal setting anywhere clears the verdict even if every test passes
    always_comb begin
        fin_ok = flag_ok[`TRM_FIN_BIT];
        syn_ok = flag_ok[`TRM_SYN_BIT];
        psh_ok = flag_ok[`TRM_PSH_BIT];
        ack_ok = flag_ok[`TRM_ACK_BIT];
        urg_ok = flag_ok[`TRM_URG_BIT];
        crit_ok = {urg_ok, ack_ok, psh_ok, syn_ok, fin_ok, port_ok};
        all_ok = (&crit_ok) & cfg_legal;
    end

    // ****************************************************************
    // Registered result
    // ****************************************************************
    // Valid pulse: one cycle behind every accepted header
    logic valid_reg;
    logic valid_next;

    always_comb begin
        valid_next = hdr_valid_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // Match: gated by the valid input so an idle cycle never shows a stale hit
    logic match_reg;
    logic match_next;

    always_comb begin
        match_next = hdr_valid_i & all_ok;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match_next;
        end
    end

    // Outputs come straight from the two flip-flops above
    assign match_o = match_reg;
    assign match_valid_o = valid_reg;

endmodule

/* test/trm_parser_model.sv */
`timescale 1ns/1ps
module trm_parser_model
    import trm_pkg::*;
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire trm_frame_hdr_t data_i,
    output logic hdr_valid_o,
    output trm_frame_hdr_t hdr_o
);
    initial begin
        hdr_o = '0;
        hdr_valid_o = 1'b0;
    end
    // Idle header is inverted so a stale value can never pass for a fresh one
    always @(posedge clk_i) begin
        hdr_valid_o <= go_i;
        hdr_o <= go_i ? data_i : ~hdr_o;
    end
endmodule

/* test/trm_rule_matcher_assertions.sv */
`timescale 1ns/1ps
module trm_rule_matcher_chk
    import trm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire trm_rule_cfg_t cfg_i,
    input wire logic hdr_valid_i,
    input wire trm_frame_hdr_t hdr_i,
    input wire logic match_valid_o,
    input wire logic match_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    function automatic logic fbad(trm_flag_sel_t s, logic b);
        return (s == TRM_FL_CLEAR && b) || (s == TRM_FL_SET && !b);
    endfunction
    wire logic v = hdr_valid_i;
    wire logic [15:0] p = hdr_i.dport;
    AST_VALID: assert property (v |=> match_valid_o)
        else $error("result missing");
    AST_IDLE: assert property (!v |=> !match_valid_o && !match_o)
        else $error("stray result");
    AST_ANY: assert property (v && cfg_i[43:42] == 2'h0 && cfg_i[9:0] == 10'h2aa |=> match_o)
        else $error("any missed");
    AST_EXACT: assert property (v && cfg_i[43:42] == 2'h1 && p != cfg_i.dport_lo |=> !match_o)
        else $error("exact false hit");
    AST_RANGE: assert property (v && cfg_i[43:42] == 2'h2
        && (p < cfg_i.dport_lo || p > cfg_i.dport_hi) |=> !match_o) else $error("range false hit");
    AST_FIN: assert property (v && fbad(cfg_i.fin_sel, hdr_i.flags[0]) |=> !match_o)
        else $error("fin false hit");
    AST_SYN: assert property (v && fbad(cfg_i.syn_sel, hdr_i.flags[1]) |=> !match_o)
        else $error("syn false hit");
    AST_PSH: assert property (v && fbad(cfg_i.psh_sel, hdr_i.flags[2]) |=> !match_o)
        else $error("psh false hit");
    AST_ACK: assert property (v && fbad(cfg_i.ack_sel, hdr_i.flags[3]) |=> !match_o)
        else $error("ack false hit");
    AST_URG: assert property (v && fbad(cfg_i.urg_sel, hdr_i.flags[4]) |=> !match_o)
        else $error("urg false hit");
    AST_BADMODE: assert property (v && cfg_i[43:42] == 2'h3 |=> !match_o)
        else $error("illegal mode hit");
    AST_BADSEL: assert property (v && cfg_i[9:8] == 2'h3 |=> !match_o)
        else $error("illegal setting hit");
    cover property (v && cfg_i[43:42] == 2'h2 ##1 match_o);
    cover property (v && cfg_i[43:42] == 2'h1 ##1 match_o);
    cover property (v ##1 !match_o);
endmodule
bind trm_rule_matcher trm_rule_matcher_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i),
    .hdr_valid_i(hdr_valid_i), .hdr_i(hdr_i), .match_valid_o(match_valid_o), .match_o(match_o));

/* test/trm_rule_matcher_test.sv */
`timescale 1ns/1ps
module trm_rule_matcher_test;
    import trm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0;
    trm_rule_cfg_t cfg = '0;
    trm_frame_hdr_t data = '0;
    trm_frame_hdr_t hdr;
    logic hv, mv, m;
    int bad_count = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    trm_parser_model par (.clk_i(clk_i), .go_i(go), .data_i(data), .hdr_valid_o(hv), .hdr_o(hdr));
    trm_rule_matcher dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .hdr_valid_i(hv),
        .hdr_i(hdr), .match_valid_o(mv), .match_o(m));
    task automatic check(logic got, logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic send(logic [15:0] pt, logic [4:0] f, logic exp);
        go = 1'b1;
        data = {pt, f};
        @(posedge clk_i);
        #1 go = 1'b0;
        @(posedge clk_i);
        #1 check(mv, 1'b1);
        check(m, exp);
    endtask
    task automatic sc_exact();
        cfg = {TRM_DP_EXACT, 16'hffff, 16'h0000, 10'h2aa};
        send(16'hffff, 5'h1f, 1'b1);
        send(16'hfffe, 5'h00, 1'b0);
        cfg = {TRM_DP_ANY, 16'hffff, 16'h0000, 10'h2aa};
        send(16'hfffe, 5'h15, 1'b1);
    endtask
    task automatic sc_range();
        cfg = {TRM_DP_RANGE, 16'h0100, 16'h0200, 10'h2aa};
        send(16'h00ff, 5'h00, 1'b0);
        send(16'h0100, 5'h00, 1'b1);
        send(16'h0200, 5'h00, 1'b1);
        send(16'h0201, 5'h00, 1'b0);
        cfg = {TRM_DP_RANGE, 16'h0200, 16'h0100, 10'h2aa};
        send(16'h0150, 5'h00, 1'b0);
    endtask
    task automatic sc_flags();
        cfg = {TRM_DP_ANY, 32'h0, 10'h2aa};
        for (int i = 0; i < 5; i++) begin
            cfg[8 - 2 * i +: 2] = TRM_FL_CLEAR;
            send(16'h1234, 5'h1f ^ (5'h01 << i), 1'b1);
            send(16'h1234, 5'h01 << i, 1'b0);
            cfg[8 - 2 * i +: 2] = TRM_FL_SET;
            send(16'h1234, 5'h01 << i, 1'b1);
            send(16'h1234, 5'h1f ^ (5'h01 << i), 1'b0);
            cfg[8 - 2 * i +: 2] = TRM_FL_ANY;
        end
    endtask
    task automatic sc_codes();
        cfg = {2'h3, 32'h0, 10'h2aa};
        send(16'h0000, 5'h00, 1'b0);
        cfg = {TRM_DP_ANY, 32'h0, 10'h3aa};
        send(16'h0000, 5'h00, 1'b0);
    endtask
    task automatic sc_reset();
        cfg = {TRM_DP_ANY, 32'h0, 10'h2aa};
        data = {16'h0000, 5'h00};
        go = 1'b1;
        @(posedge clk_i);
        #1 go = 1'b0;
        rst_i = 1'b1;
        @(posedge clk_i);
        #1 rst_i = 1'b0;
        check(mv, 1'b0);
        check(m, 1'b0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_i = 1'b0;
        check(mv, 1'b0);
        sc_exact();
        sc_range();
        sc_flags();
        sc_codes();
        sc_reset();
        sc_exact();
        give_verdict();
    end
endmodule
